// ---- src/adc_sequencing_control.sv ----
// The placing of the registers and register access over APB were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module adc_sequencing_control (
  input wire logic CLK_SYS,
  input wire logic NRST,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [adc_ctrl_pkg::ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0] PSTRB,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Analog converter core
  input wire logic [adc_ctrl_pkg::RESULT_W-1:0] CONV_DATA,
  output logic CONV_POWER,
  output logic CONV_SAMPLE,
  output logic CONV_CLK_EN,
  output logic [adc_ctrl_pkg::NUM_EXT-1:0] EXT_CHANNEL_CONNECT,
  output logic [adc_ctrl_pkg::NUM_INT-1:0] INT_SIGNAL_CONNECT,
  output logic GROUND_CONNECT,
  // Reference and amplifier
  output logic REF_SUPPLY,
  output logic REF_PIN,
  output logic REF_AMP,
  output logic AMP_ENABLE,
  output logic AMP_INPUT_SEL,
  output logic [1:0] AMP_GAIN_SEL,
  output logic BANDGAP_ENABLE,
  // Pin function control
  input wire logic [adc_ctrl_pkg::NUM_EXT-1:0] PIN_ANALOG_SEL,
  output logic [adc_ctrl_pkg::NUM_EXT-1:0] PIN_DIGITAL_OFF,
  output logic [adc_ctrl_pkg::NUM_EXT-1:0] PIN_PULLUP_OFF
);
  import adc_ctrl_pkg::*;

  // Software-visible control state
  logic start_bit;
  logic conv_enable;
  logic result_format;
  logic [3:0] ext_channel_sel;
  logic [3:0] input_signal_sel;
  logic [CLKSEL_W-1:0] conv_clock_sel;
  logic amp_enable;
  logic amp_input_sel;
  logic [1:0] reference_sel;
  logic [1:0] amp_gain_sel;
  logic bandgap_enable;
  logic [7:0] result_low;
  logic [7:0] result_high;

  // Sequencer state
  conv_state_t state;
  conv_state_t next_state;
  logic start_armed;
  logic start_fire;
  logic done;
  logic conv_busy;
  logic [TICK_CNT_W-1:0] tick_count;

  // Bus decode
  logic wr_access;
  logic rd_setup;
  logic lane0;
  logic addr_hit;
  logic [7:0] rd_byte;
  logic [7:0] wbyte;

  conv_clock_if clk_if ();
  conv_clock_divider u_divider (
    .clk(CLK_SYS),
    .nrst(NRST),
    .clk_if(clk_if)
  );

  // Zero-wait slave: write lands at the access edge, read data is fetched at setup
  assign PREADY = 1'b1;
  assign wr_access = PSEL && PENABLE && PWRITE && addr_hit;
  assign rd_setup = PSEL && !PENABLE && !PWRITE;
  assign lane0 = PSTRB[0];
  assign wbyte = PWDATA[7:0];

  // Address decode against the six mapped words
  always_comb begin
    case (PADDR)
      OFS_RESULT_LOW,
      OFS_RESULT_HIGH,
      OFS_CONV_CONTROL_0,
      OFS_CONV_CONTROL_1,
      OFS_CONV_CONTROL_2,
      OFS_BANDGAP_CONTROL: addr_hit = 1'b1;
      default: addr_hit = 1'b0;
    endcase
  end

  // Error only in access phase of an unmapped address
  assign PSLVERR = PSEL && PENABLE && !addr_hit;

  // Read mux; unimplemented bits read as zero
  always_comb begin
    rd_byte = 8'h00;
    case (PADDR)
      OFS_RESULT_LOW: rd_byte = result_low;
      OFS_RESULT_HIGH: rd_byte = result_high;
      OFS_CONV_CONTROL_0: begin
        rd_byte[START_POS] = start_bit;
        rd_byte[BUSY_POS] = conv_busy;
        rd_byte[ENABLE_POS] = conv_enable;
        rd_byte[FORMAT_POS] = result_format;
        rd_byte[3:0] = ext_channel_sel;
      end
      OFS_CONV_CONTROL_1: begin
        rd_byte[INSEL_POS +: 4] = input_signal_sel;
        rd_byte[CLKSEL_POS +: CLKSEL_W] = conv_clock_sel;
      end
      OFS_CONV_CONTROL_2: begin
        rd_byte[AMP_EN_POS] = amp_enable;
        rd_byte[AMP_IN_POS] = amp_input_sel;
        rd_byte[REF_POS +: 2] = reference_sel;
        rd_byte[GAIN_POS +: 2] = amp_gain_sel;
      end
      OFS_BANDGAP_CONTROL: rd_byte[BANDGAP_POS] = bandgap_enable;
      default: rd_byte = 8'h00;
    endcase
  end

  // Read data held in a flop from the setup cycle through the access cycle
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      PRDATA <= 32'h0000_0000;
    end else if (rd_setup) begin
      PRDATA <= {24'h00_0000, rd_byte};
    end
  end

  // Control register 0 writable fields; busy has no write path
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      start_bit <= RST_CONTROL[START_POS];
      conv_enable <= RST_CONTROL[ENABLE_POS];
      result_format <= RST_CONTROL[FORMAT_POS];
      ext_channel_sel <= RST_CONTROL[3:0];
    end else if (wr_access && lane0 && PADDR == OFS_CONV_CONTROL_0) begin
      start_bit <= wbyte[START_POS];
      conv_enable <= wbyte[ENABLE_POS];
      result_format <= wbyte[FORMAT_POS];
      ext_channel_sel <= wbyte[3:0];
    end
  end

  // Control register 1: input select and conversion clock select
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      input_signal_sel <= RST_CONTROL[INSEL_POS +: 4];
      conv_clock_sel <= RST_CONTROL[CLKSEL_POS +: CLKSEL_W];
    end else if (wr_access && lane0 && PADDR == OFS_CONV_CONTROL_1) begin
      input_signal_sel <= wbyte[INSEL_POS +: 4];
      conv_clock_sel <= wbyte[CLKSEL_POS +: CLKSEL_W];
    end
  end

  // Control register 2 owns the whole amplifier setup
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      amp_enable <= RST_CONTROL[AMP_EN_POS];
      amp_input_sel <= RST_CONTROL[AMP_IN_POS];
      reference_sel <= RST_CONTROL[REF_POS +: 2];
      amp_gain_sel <= RST_CONTROL[GAIN_POS +: 2];
    end else if (wr_access && lane0 && PADDR == OFS_CONV_CONTROL_2) begin
      amp_enable <= wbyte[AMP_EN_POS];
      amp_input_sel <= wbyte[AMP_IN_POS];
      reference_sel <= wbyte[REF_POS +: 2];
      amp_gain_sel <= wbyte[GAIN_POS +: 2];
    end
  end

  // Bandgap switch in a register of its own
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      bandgap_enable <= RST_CONTROL[BANDGAP_POS];
    end else if (wr_access && lane0 && PADDR == OFS_BANDGAP_CONTROL) begin
      bandgap_enable <= wbyte[BANDGAP_POS];
    end
  end

  // Arm on a 0-to-1 write of start, fire on the following 1-to-0 write
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      start_armed <= 1'b0;
    end else if (wr_access && lane0 && PADDR == OFS_CONV_CONTROL_0) begin
      if (!start_bit && wbyte[START_POS]) begin
        start_armed <= 1'b1;
      end else if (!wbyte[START_POS]) begin
        start_armed <= 1'b0;
      end
    end
  end

  // Fire only when enabled and the single converter is free
  assign start_fire = wr_access && lane0 && PADDR == OFS_CONV_CONTROL_0
                      && start_armed && start_bit && !wbyte[START_POS]
                      && conv_enable && wbyte[ENABLE_POS] && state == ST_IDLE;

  // Last tick of the fixed-length conversion
  assign done = state == ST_CONVERT && clk_if.tick && tick_count == LAST_TICK;

  // Sequencer: disabling mid-conversion abandons it without touching results
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (start_fire) begin
          next_state = ST_CONVERT;
        end
      end
      ST_CONVERT: begin
        if (done || !conv_enable) begin
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  assign conv_busy = state == ST_CONVERT;
  // Tick counter restarts with every conversion
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      tick_count <= '0;
    end else if (state != ST_CONVERT) begin
      tick_count <= '0;
    end else if (clk_if.tick) begin
      tick_count <= tick_count + TICK_CNT_W'(1);
    end
  end

  // Divider runs only while converting, at the selected rate
  assign clk_if.sel = conv_clock_sel;
  assign clk_if.run = conv_busy;

  // Result captured in the same cycle busy drops; never while disabled
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      result_high <= 8'h00;
      result_low <= 8'h00;
    end else if (done && conv_enable) begin
      if (result_format) begin
        result_high <= {4'h0, CONV_DATA[11:8]};
        result_low <= CONV_DATA[7:0];
      end else begin
        result_high <= CONV_DATA[11:4];
        result_low <= {CONV_DATA[3:0], 4'h0};
      end
    end
  end

  // Conversion strobes toward the core
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      CONV_SAMPLE <= 1'b0;
      CONV_CLK_EN <= 1'b0;
    end else begin
      CONV_SAMPLE <= start_fire;
      CONV_CLK_EN <= clk_if.tick && conv_busy;
    end
  end

  // Input signal decode
  logic ext_selected;
  logic [NUM_INT-1:0] next_int_connect;
  logic next_ground;
  logic [NUM_EXT-1:0] next_ext_connect;

  always_comb begin
    ext_selected = 1'b0;
    next_int_connect = '0;
    next_ground = 1'b0;
    case (input_signal_sel)
      4'h0, 4'h4, 4'hc, 4'hd, 4'he, 4'hf: ext_selected = 1'b1;
      4'h1: next_int_connect[0] = 1'b1;
      4'h2: next_int_connect[1] = 1'b1;
      4'h3: next_int_connect[2] = 1'b1;
      4'h5: next_int_connect[3] = 1'b1;
      4'h6: next_int_connect[4] = 1'b1;
      4'h7: next_int_connect[5] = 1'b1;
      default: next_ground = 1'b1;
    endcase
  end
  // Per-channel connect and pin takeover
  logic [NUM_EXT-1:0] next_digital_off;
  logic [NUM_EXT-1:0] next_pullup_off;

  genvar ch;
  generate
    for (ch = 0; ch < NUM_EXT; ch++) begin : g_channel
      // Codes 13..15 match no channel and leave all open
      assign next_ext_connect[ch] = ext_selected
                                    && ext_channel_sel == 4'(ch);
      assign next_digital_off[ch] = PIN_ANALOG_SEL[ch];
      assign next_pullup_off[ch] = PIN_ANALOG_SEL[ch];
    end
  endgenerate

  // Analog controls registered so the switches never see decode glitches
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      EXT_CHANNEL_CONNECT <= '0;
      INT_SIGNAL_CONNECT <= '0;
      GROUND_CONNECT <= 1'b0;
      PIN_DIGITAL_OFF <= '0;
      PIN_PULLUP_OFF <= '0;
    end else begin
      EXT_CHANNEL_CONNECT <= next_ext_connect;
      INT_SIGNAL_CONNECT <= next_int_connect;
      GROUND_CONNECT <= next_ground;
      PIN_DIGITAL_OFF <= next_digital_off;
      PIN_PULLUP_OFF <= next_pullup_off;
    end
  end

  // Power, reference and amplifier outputs
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      CONV_POWER <= 1'b0;
      REF_SUPPLY <= 1'b0;
      REF_PIN <= 1'b0;
      REF_AMP <= 1'b0;
      AMP_ENABLE <= 1'b0;
      AMP_INPUT_SEL <= 1'b0;
      AMP_GAIN_SEL <= 2'h0;
      BANDGAP_ENABLE <= 1'b0;
    end else begin
      CONV_POWER <= conv_enable;
      REF_SUPPLY <= reference_sel == 2'h0;
      REF_PIN <= reference_sel == 2'h1;
      REF_AMP <= reference_sel[1];
      AMP_ENABLE <= amp_enable;
      AMP_INPUT_SEL <= amp_input_sel;
      AMP_GAIN_SEL <= amp_gain_sel;
      BANDGAP_ENABLE <= bandgap_enable;
    end
  end
endmodule : adc_sequencing_control
`default_nettype wire

// ---- src/adc_ctrl_pkg.sv ----
`default_nettype none
package adc_ctrl_pkg;
  // Register byte offsets on the APB bus
  localparam logic [7:0] OFS_RESULT_LOW = 8'h00;
  localparam logic [7:0] OFS_RESULT_HIGH = 8'h04;
  localparam logic [7:0] OFS_CONV_CONTROL_0 = 8'h08;
  localparam logic [7:0] OFS_CONV_CONTROL_1 = 8'h0c;
  localparam logic [7:0] OFS_CONV_CONTROL_2 = 8'h10;
  localparam logic [7:0] OFS_BANDGAP_CONTROL = 8'h14;
  localparam int ADDR_W = 8;

  // conv_control_0 field positions
  localparam int START_POS = 7;
  localparam int BUSY_POS = 6;
  localparam int ENABLE_POS = 5;
  localparam int FORMAT_POS = 4;
  // conv_control_1 field positions
  localparam int INSEL_POS = 4;
  localparam int CLKSEL_POS = 0;
  // conv_control_2 field positions
  localparam int AMP_EN_POS = 7;
  localparam int AMP_IN_POS = 4;
  localparam int REF_POS = 2;
  localparam int GAIN_POS = 0;
  // bandgap_control field position
  localparam int BANDGAP_POS = 0;

  // Reset values
  localparam logic [7:0] RST_CONTROL = 8'h00;
  localparam logic [11:0] RST_RESULT = 12'h000;

  // Converter geometry
  localparam int RESULT_W = 12;
  localparam int NUM_EXT = 13;
  localparam int NUM_INT = 6;
  localparam int CLKSEL_W = 3;
  localparam int DIV_W = 7;

  // Conversion length in conversion-clock ticks
  localparam int CONV_TICKS = 16;
  localparam int TICK_CNT_W = 5;
  localparam logic [TICK_CNT_W-1:0] LAST_TICK = TICK_CNT_W'(CONV_TICKS - 1);

  // Sequencer states, one-hot
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_CONVERT = 2'b10
  } conv_state_t;
endpackage : adc_ctrl_pkg
`default_nettype wire

// ---- src/conv_clock_if.sv ----
`timescale 1ns/10ps
`default_nettype none
interface conv_clock_if;
  import adc_ctrl_pkg::*;
  logic [CLKSEL_W-1:0] sel;
  logic run;
  logic tick;
  // Sequencer side selects the rate and reads the enable pulse
  modport ctrl (output sel, output run, input tick);
  // Divider side
  modport div (input sel, input run, output tick);
endinterface : conv_clock_if
`default_nettype wire

// ---- src/conv_clock_divider.sv ----
`timescale 1ns/10ps
`default_nettype none
module conv_clock_divider (
  input wire logic clk,
  input wire logic nrst,
  conv_clock_if.div clk_if
);
  import adc_ctrl_pkg::*;

  logic [DIV_W-1:0] count;
  logic [DIV_W-1:0] mask;

  // Mask of low bits that must all be ones for the selected divide ratio
  always_comb begin
    mask = DIV_W'((8'h01 << clk_if.sel) - 8'h01);
  end

  // Counter only runs during a conversion, so each one starts phase-aligned
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      count <= '0;
    end else if (!clk_if.run) begin
      count <= '0;
    end else begin
      count <= count + DIV_W'(1);
    end
  end

  // One-cycle enable every 2^sel system clocks
  assign clk_if.tick = clk_if.run && ((count & mask) == mask);
endmodule : conv_clock_divider
`default_nettype wire

// ---- src/none_placeholder_removed.sv ----
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

// ---- testbench/analog_core_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module analog_core_model
  import adc_ctrl_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic conv_power,
  input wire logic conv_sample,
  input wire logic conv_clk_en,
  input wire logic [11:0] sample_value,
  output logic [11:0] conv_data
);
  logic [11:0] hold;
  logic [11:0] junk;
  logic [4:0] left;
  // One sample held for one whole conversion, one circuit only
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      hold <= 12'h000;
      left <= 5'h00;
    end else if (conv_sample) begin
      hold <= sample_value;
      left <= 5'(CONV_TICKS);
    end else if (conv_clk_en && left != 5'h00) begin
      left <= left - 5'h01;
    end
  end
  // Idle output keeps moving so a capture at the wrong moment shows
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      junk <= 12'h000;
    end else begin
      junk <= {junk[10:0], ~junk[11]};
    end
  end
  assign conv_data = (left != 5'h00 && conv_power) ? hold : junk;
endmodule : analog_core_model
`default_nettype wire

// ---- testbench/adc_sequencing_control_props.sv ----
`timescale 1ns/10ps
`default_nettype none
module adc_ctrl_checker
  import adc_ctrl_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic NRST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [adc_ctrl_pkg::ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0] PSTRB,
  input wire logic [31:0] PRDATA,
  input wire logic PSLVERR,
  input wire logic CONV_POWER,
  input wire logic CONV_SAMPLE,
  input wire logic CONV_CLK_EN,
  input wire logic [adc_ctrl_pkg::NUM_EXT-1:0] EXT_CHANNEL_CONNECT,
  input wire logic [adc_ctrl_pkg::NUM_INT-1:0] INT_SIGNAL_CONNECT,
  input wire logic REF_SUPPLY,
  input wire logic REF_PIN,
  input wire logic REF_AMP,
  input wire logic AMP_ENABLE,
  input wire logic [1:0] AMP_GAIN_SEL,
  input wire logic [adc_ctrl_pkg::NUM_EXT-1:0] PIN_ANALOG_SEL,
  input wire logic [adc_ctrl_pkg::NUM_EXT-1:0] PIN_DIGITAL_OFF,
  input wire logic [adc_ctrl_pkg::NUM_EXT-1:0] PIN_PULLUP_OFF
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!NRST);
  logic wr;
  logic [2:0] sel;
  logic [8:0] gap;
  logic [4:0] npulse;
  // Accepted write strobe as seen on the bus
  assign wr = PSEL && PENABLE && PWRITE && PSTRB[0];
  // Rate code shadowed from bus writes; the bench never changes it mid-run
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      sel <= 3'h0;
    end else if (wr && PADDR == OFS_CONV_CONTROL_1) begin
      sel <= PWDATA[2:0];
    end
  end
  // Distance between ticks and ticks per conversion
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      gap <= 9'h000;
      npulse <= 5'h00;
    end else begin
      gap <= CONV_CLK_EN ? 9'h001 : (gap == 9'h1ff ? gap : gap + 9'h001);
      npulse <= CONV_SAMPLE ? 5'h00 : npulse + 5'(CONV_CLK_EN);
    end
  end
  power_follow_a: assert property (wr && PADDR == OFS_CONV_CONTROL_0
    |=> ##1 CONV_POWER == $past(PWDATA[ENABLE_POS], 2)) else $error("power level wrong");
  start_seq_a: assert property (CONV_SAMPLE |-> CONV_POWER && $past(wr &&
    PADDR == OFS_CONV_CONTROL_0 && !PWDATA[START_POS])) else $error("start without sequence");
  one_conv_a: assert property (CONV_SAMPLE |=> !CONV_SAMPLE [*8])
    else $error("second sample during conversion");
  tick_gap_a: assert property (CONV_CLK_EN && npulse != 5'h00
    |-> gap == (9'h001 << sel)) else $error("tick spacing wrong");
  tick_count_a: assert property (CONV_CLK_EN |-> npulse < 5'(CONV_TICKS))
    else $error("too many ticks");
  ext_off_a: assert property (|INT_SIGNAL_CONNECT |-> EXT_CHANNEL_CONNECT == '0)
    else $error("external input left on");
  one_input_a: assert property ($onehot0(EXT_CHANNEL_CONNECT) && $onehot0(INT_SIGNAL_CONNECT))
    else $error("several inputs on");
  ref_decode_a: assert property ($past(NRST) |-> $onehot({REF_SUPPLY, REF_PIN, REF_AMP}))
    else $error("reference decode wrong");
  amp_mirror_a: assert property (wr && PADDR == OFS_CONV_CONTROL_2 |=> ##1
    AMP_ENABLE == $past(PWDATA[AMP_EN_POS], 2) && AMP_GAIN_SEL == $past(PWDATA[1:0], 2))
    else $error("amplifier field wrong");
  pin_takeover_a: assert property ($past(NRST) |-> PIN_DIGITAL_OFF == $past(PIN_ANALOG_SEL)
    && PIN_PULLUP_OFF == $past(PIN_ANALOG_SEL)) else $error("pin takeover wrong");
  rdata_zero_a: assert property (PSEL && PENABLE && !PWRITE |-> PRDATA[31:8] == 24'h000000)
    else $error("upper read bits set");
  unmapped_err_a: assert property (PSEL && PENABLE && PADDR > OFS_BANDGAP_CONTROL |-> PSLVERR)
    else $error("no error on unmapped access");
endmodule : adc_ctrl_checker
bind adc_sequencing_control adc_ctrl_checker u_chk (.CLK_SYS, .NRST, .PSEL, .PENABLE, .PWRITE,
  .PADDR, .PWDATA, .PSTRB, .PRDATA, .PSLVERR, .CONV_POWER, .CONV_SAMPLE, .CONV_CLK_EN,
  .EXT_CHANNEL_CONNECT, .INT_SIGNAL_CONNECT, .REF_SUPPLY, .REF_PIN, .REF_AMP, .AMP_ENABLE,
  .AMP_GAIN_SEL, .PIN_ANALOG_SEL, .PIN_DIGITAL_OFF, .PIN_PULLUP_OFF);
`default_nettype wire

// ---- testbench/adc_sequencing_control_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
module adc_sequencing_control_tb;
  import adc_ctrl_pkg::*;
  logic CLK_SYS = 1'b0, NRST = 1'b0, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0, quiet = 1'b0;
  logic [7:0] PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0, PRDATA, rd;
  logic [3:0] PSTRB = 4'hf;
  logic [11:0] sample_value = 12'h000, CONV_DATA;
  logic [12:0] PIN_ANALOG_SEL = 13'h0, EXT_CHANNEL_CONNECT, PIN_DIGITAL_OFF, PIN_PULLUP_OFF;
  logic [5:0] INT_SIGNAL_CONNECT;
  logic [1:0] AMP_GAIN_SEL;
  logic PREADY, PSLVERR, CONV_POWER, CONV_SAMPLE, CONV_CLK_EN, GROUND_CONNECT, err;
  logic REF_SUPPLY, REF_PIN, REF_AMP, AMP_ENABLE, AMP_INPUT_SEL, BANDGAP_ENABLE;
  logic [31:0] expq[$];
  int bad_count = 0, tests_run = 0;
  initial forever #2 CLK_SYS = ~CLK_SYS;
  adc_sequencing_control DUT (.CLK_SYS, .NRST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PSTRB,
    .PRDATA, .PREADY, .PSLVERR, .CONV_DATA, .CONV_POWER, .CONV_SAMPLE, .CONV_CLK_EN,
    .EXT_CHANNEL_CONNECT, .INT_SIGNAL_CONNECT, .GROUND_CONNECT, .REF_SUPPLY, .REF_PIN, .REF_AMP,
    .AMP_ENABLE, .AMP_INPUT_SEL, .AMP_GAIN_SEL, .BANDGAP_ENABLE, .PIN_ANALOG_SEL,
    .PIN_DIGITAL_OFF, .PIN_PULLUP_OFF);
  analog_core_model model (.clk(CLK_SYS), .nrst(NRST), .conv_power(CONV_POWER),
    .conv_sample(CONV_SAMPLE), .conv_clk_en(CONV_CLK_EN), .sample_value(sample_value),
    .conv_data(CONV_DATA));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic final_report;
    $display("tests_run=%0d bad_count=%0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : final_report
  // One APB transfer; read data and error are taken at the ready edge only
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge CLK_SYS);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK_SYS);
    PENABLE <= 1'b1;
    n = 0;
    do begin
      @(posedge CLK_SYS);
      n++;
    end while (PREADY !== 1'b1 && n < 50);
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    if (n >= 50) begin
      bad_count++;
      final_report();
    end
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rd_exp(input logic [7:0] a, input logic [31:0] e);
    expq.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask : rd_exp
  // Read results are judged here, in order of issue
  always @(posedge CLK_SYS) begin
    if (PSEL && PENABLE && !PWRITE && PREADY && !quiet) check(PRDATA, expq.pop_front());
  end
  task automatic results(input logic f, input logic [11:0] v);
    rd_exp(OFS_RESULT_HIGH, f ? {28'h0, v[11:8]} : {24'h0, v[11:4]});
    rd_exp(OFS_RESULT_LOW, f ? {24'h0, v[7:0]} : {24'h0, v[3:0], 4'h0});
  endtask : results
  // Full start sequence, then poll busy until it drops
  task automatic conv(input logic [2:0] s, input logic f, input logic [11:0] v);
    int n;
    sample_value <= v;
    wr(OFS_CONV_CONTROL_1, {29'h0, s});
    wr(OFS_CONV_CONTROL_0, {24'h0, 3'b101, f, 4'h0});
    rd_exp(OFS_CONV_CONTROL_0, {24'h0, 3'b101, f, 4'h0});
    wr(OFS_CONV_CONTROL_0, {24'h0, 3'b001, f, 4'h0});
    rd_exp(OFS_CONV_CONTROL_0, {24'h0, 3'b011, f, 4'h0});
    check(CONV_POWER, 1'b1);
    quiet <= 1'b1;
    n = 0;
    do begin
      apb(1'b0, OFS_CONV_CONTROL_0, 32'h0);
      n++;
    end while (rd[BUSY_POS] !== 1'b0 && n < 1000);
    quiet <= 1'b0;
    if (n >= 1000) begin
      bad_count++;
      final_report();
    end
    check(rd, {24'h0, 3'b001, f, 4'h0});
  endtask : conv
  initial begin
    logic [11:0] v;
    logic [31:0] d;
    logic [12:0] e;
    logic [5:0] ii;
    int c, ch;
    void'($urandom(32'h0224));
    repeat (10) @(posedge CLK_SYS);
    NRST <= 1'b1;
    for (int i = 0; i < 6; i++) rd_exp(8'(4 * i), 32'h0);
    rd_exp(8'h18, 32'h0);
    check(err, 1'b1);
    wr(OFS_CONV_CONTROL_0, 32'h40);
    rd_exp(OFS_CONV_CONTROL_0, 32'h0);
    $display("test reset and access done");
    for (int i = 0; i < 8; i++) begin
      v = 12'($urandom);
      conv(3'(i), i[0], v);
      results(i[0], v);
    end
    $display("test conversions done");
    // Start while disabled is dropped; an abort leaves the stored result alone
    wr(OFS_CONV_CONTROL_0, 32'h90);
    wr(OFS_CONV_CONTROL_0, 32'h10);
    rd_exp(OFS_CONV_CONTROL_0, 32'h10);
    sample_value <= ~v;
    wr(OFS_CONV_CONTROL_0, 32'hb0);
    wr(OFS_CONV_CONTROL_0, 32'h30);
    // A second start while busy must be dropped, busy stays set
    wr(OFS_CONV_CONTROL_0, 32'hb0);
    wr(OFS_CONV_CONTROL_0, 32'h30);
    rd_exp(OFS_CONV_CONTROL_0, 32'h70);
    wr(OFS_CONV_CONTROL_0, 32'h10);
    results(1'b1, v);
    check(CONV_POWER, 1'b0);
    $display("test disable done");
    for (c = 0; c < 16; c++) begin
      ch = $urandom_range(15, 0);
      wr(OFS_CONV_CONTROL_1, 32'(c) << 4);
      wr(OFS_CONV_CONTROL_0, 32'(ch));
      @(posedge CLK_SYS);
      #1;
      e = ((c == 0 || c == 4 || c >= 12) && ch < 13) ? 13'h1 << ch : 13'h0;
      ii = (c >= 1 && c <= 3) ? 6'h1 << (c - 1) : (c >= 5 && c <= 7) ? 6'h1 << (c - 2) : 6'h0;
      check(EXT_CHANNEL_CONNECT, e);
      check(INT_SIGNAL_CONNECT, ii);
      check(GROUND_CONNECT, c >= 8 && c <= 11);
    end
    $display("test input select done");
    for (int i = 0; i < 6; i++) begin
      d = $urandom;
      wr(OFS_CONV_CONTROL_2, d);
      rd_exp(OFS_CONV_CONTROL_2, d & 32'h9f);
      #1;
      check({REF_AMP, REF_PIN, REF_SUPPLY}, d[3] ? 3'h4 : d[2] ? 3'h2 : 3'h1);
      check({AMP_ENABLE, AMP_INPUT_SEL, AMP_GAIN_SEL}, {d[7], d[4], d[1:0]});
    end
    wr(OFS_BANDGAP_CONTROL, 32'hff);
    rd_exp(OFS_BANDGAP_CONTROL, 32'h01);
    PSTRB <= 4'h0;
    #1;
    check(BANDGAP_ENABLE, 1'b1);
    wr(OFS_BANDGAP_CONTROL, 32'h00);
    PSTRB <= 4'hf;
    rd_exp(OFS_BANDGAP_CONTROL, 32'h01);
    $display("test reference and amplifier done");
    for (int i = 0; i < 4; i++) begin
      @(posedge CLK_SYS);
      PIN_ANALOG_SEL <= 13'($urandom);
      repeat (2) @(posedge CLK_SYS);
      #1;
      check(PIN_DIGITAL_OFF, PIN_ANALOG_SEL);
      check(PIN_PULLUP_OFF, PIN_ANALOG_SEL);
    end
    $display("test pin takeover done");
    final_report();
  end
endmodule : adc_sequencing_control_tb
`default_nettype wire
